// file: rtl/drive_err_pkg.sv
// Purpose: Shared constants and types for the drive error reporting block.
// Assumes: One 100 MHz clock; all codes are 16-bit diagnostic codes.
// Notes:   Bit positions index the 32-bit warning and fault latch words.
package drive_err_pkg;

	localparam int CODE_W  = 16;
	localparam int CLASS_W = 3;
	localparam int WORD_W  = 32;
	localparam int BIT_W   = 5;

	// Diagnostic codes.
	localparam logic [CODE_W-1:0] CODE_NONE        = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_ENCODER     = 16'h7329;
	localparam logic [CODE_W-1:0] CODE_ABS_POS     = 16'h7338;
	localparam logic [CODE_W-1:0] CODE_RX_OVERFLOW = 16'h7500;
	localparam logic [CODE_W-1:0] CODE_RX_FRAMING  = 16'h7501;
	localparam logic [CODE_W-1:0] CODE_RX_PARITY   = 16'h7502;
	localparam logic [CODE_W-1:0] CODE_RX_GENERAL  = 16'h7503;
	localparam logic [CODE_W-1:0] CODE_HALT_DECEL  = 16'ha300;
	localparam logic [CODE_W-1:0] CODE_QSTOP       = 16'ha301;
	localparam logic [CODE_W-1:0] CODE_LIMIT_POS   = 16'ha302;
	localparam logic [CODE_W-1:0] CODE_LIMIT_NEG   = 16'ha303;
	localparam logic [CODE_W-1:0] CODE_NOT_READY   = 16'ha305;
	localparam logic [CODE_W-1:0] CODE_SW_STOP     = 16'ha306;
	localparam logic [CODE_W-1:0] CODE_INT_STOP    = 16'ha307;
	localparam logic [CODE_W-1:0] CODE_FAULT_STATE = 16'ha308;

	// Error classes.
	localparam logic [CLASS_W-1:0] CLASS_0 = 3'h0;
	localparam logic [CLASS_W-1:0] CLASS_1 = 3'h1;

	// Warning latch word bit positions.
	localparam logic [BIT_W-1:0] WARN_BIT_ENCODER = 5'h08;
	localparam logic [BIT_W-1:0] WARN_BIT_MODBUS  = 5'h09;
	localparam logic [BIT_W-1:0] WARN_BIT_ABS_POS = 5'h0d;

	// Fault latch word bit positions.
	localparam logic [BIT_W-1:0] FAULT_BIT_LIMIT   = 5'h01;
	localparam logic [BIT_W-1:0] FAULT_BIT_SW_STOP = 5'h03;

	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

	// Number of pin-level condition inputs that are synchronised.
	localparam int PIN_N = 11;

	typedef enum logic [1:0]
	{
		CMD_ENABLE,
		CMD_MODE,
		CMD_DISABLE,
		CMD_OTHER
	} cmd_t;

	typedef enum
	{
		ST_NOT_READY,
		ST_READY,
		ST_ENABLED,
		ST_QSTOP,
		ST_FAULT_REACTION,
		ST_FAULT
	} drive_state_t;

	function automatic logic [WORD_W-1:0] bit_mask(input logic [BIT_W-1:0] pos);
		bit_mask = WORD_ZERO;
		bit_mask[pos] = 1'b1;
	endfunction

endpackage

// file: rtl/latch_if.sv
// Purpose: Carrier between the reporting top and a sticky latch word.
// Assumes: Single clock domain.
// Notes:   set_mask wins over clr in the owner.
`timescale 1ns/1ps
interface latch_if;
	import drive_err_pkg::*;
	logic [WORD_W-1:0] set_mask;
	logic              clr;
	logic [WORD_W-1:0] word;
	modport owner (input set_mask, input clr, output word);
	modport user  (output set_mask, output clr, input word);
endinterface

// file: rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs are quasi-static relative to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync
#(
	parameter int N = 1
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [N-1:0] async_in,
	output logic      [N-1:0] sync_out
);
	logic [N-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// file: rtl/latch_word.sv
// Purpose: Sticky 32-bit latch word, set by events and cleared by fault reset.
// Assumes: Single clock domain.
// Notes:   A bit set in the clearing cycle stays set, so no event is lost.
`timescale 1ns/1ps
module latch_word
	import drive_err_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Latch access
	latch_if.owner    lw
);
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] word_next;

	assign word_next = (lw.clr ? WORD_ZERO : word_reg) | lw.set_mask;
	assign lw.word   = word_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			word_reg <= WORD_ZERO;
		else
			word_reg <= word_next;
	end
endmodule

// file: rtl/drive_error_reporting.sv
// Purpose: Error detection, latching and command refusal of a motor drive.
// Assumes: Pin conditions are asynchronous; host strobes are on clk.
// Notes:   Responses come one cycle after the command strobe.
// Behaviour
// - Encoder error reports 7329, warning bit 8.
// - Unknown absolute position reports 7338, warning bit 13.
// - Modbus overflow reports 7500, warning bit 9.
// - Modbus framing fault reports 7501, warning bit 9.
// - Modbus parity fault reports 7502, warning bit 9.
// - Modbus receive fault reports 7503, warning bit 9.
// - Command during halt deceleration refused with A300.
// - Class-1 error forces quick stop, reports A301.
// - Positive limit stops, reports A302, fault bit 1.
// - Negative limit stops, reports A303, fault bit 1.
// - Enable in not-ready state refused with A305.
// - Host software stop: quick stop, A306, bit 3.
// - Mode activation after software stop answered A306.
// - Internal stop of homing/jog answers A307.
// - Mode activations refused by a software, internal or quick stop resume only after fault reset.
// - Class-2 error enters fault; refusals answer A308.
`timescale 1ns/1ps
module drive_error_reporting
	import drive_err_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Asynchronous condition pins
	input  wire logic                encoder_err,
	input  wire logic                abs_pos_unknown,
	input  wire logic                rx_overflow,
	input  wire logic                rx_framing,
	input  wire logic                rx_parity,
	input  wire logic                rx_general,
	input  wire logic                limit_pos,
	input  wire logic                limit_neg,
	input  wire logic                halt_req,
	input  wire logic                standstill,
	input  wire logic                init_done,
	// Internal events on clk
	input  wire logic                class1_err,
	input  wire logic                class2_err,
	input  wire logic                int_sw_stop,
	input  wire logic                homing_jog_active,
	// Host requests on clk
	input  wire logic                cmd_valid,
	input  wire drive_err_pkg::cmd_t cmd_kind,
	input  wire logic                sw_stop_req,
	input  wire logic                fault_reset,
	// Command response
	output logic                     resp_valid,
	output logic                     resp_refused,
	output logic [drive_err_pkg::CODE_W-1:0]  resp_code,
	// Status
	output logic [drive_err_pkg::WORD_W-1:0]  warning_latch_word,
	output logic [drive_err_pkg::WORD_W-1:0]  fault_latch_word,
	output logic [drive_err_pkg::CODE_W-1:0]  last_code,
	output logic [drive_err_pkg::CLASS_W-1:0] last_class,
	output logic                     power_stage_on,
	output logic                     quick_stop_active,
	output logic                     fault_active,
	output logic                     motion_stop
);
	latch_if warn_lw ();
	latch_if fault_lw ();

	logic [PIN_N-1:0] pins_sync;
	logic [PIN_N-1:0] pins_prev_reg;
	logic [PIN_N-1:0] pins_rise;

	drive_state_t state_reg;
	drive_state_t state_next;

	logic              sw_stop_reg;
	logic              int_stop_reg;
	logic              halt_seen_reg;
	logic              resp_valid_reg;
	logic              resp_refused_reg;
	logic [CODE_W-1:0] resp_code_reg;
	logic [CODE_W-1:0] last_code_reg;
	logic [CLASS_W-1:0] last_class_reg;

	pin_sync #(.N(PIN_N)) u_sync
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({init_done, standstill, halt_req, limit_neg, limit_pos,
		            rx_general, rx_parity, rx_framing, rx_overflow,
		            abs_pos_unknown, encoder_err}),
		.sync_out (pins_sync)
	);

	latch_word u_warn
	(
		.clk   (clk),
		.rst_n (rst_n),
		.lw    (warn_lw.owner)
	);

	latch_word u_fault
	(
		.clk   (clk),
		.rst_n (rst_n),
		.lw    (fault_lw.owner)
	);

	// Named views of the synchronised levels.
	wire s_encoder   = pins_sync[0];
	wire s_abs_pos   = pins_sync[1];
	wire s_overflow  = pins_sync[2];
	wire s_framing   = pins_sync[3];
	wire s_parity    = pins_sync[4];
	wire s_rx_gen    = pins_sync[5];
	wire s_lim_pos   = pins_sync[6];
	wire s_lim_neg   = pins_sync[7];
	wire s_halt      = pins_sync[8];
	wire s_still     = pins_sync[9];
	wire s_init_done = pins_sync[10];

	assign pins_rise = pins_sync & ~pins_prev_reg;

	wire modbus_any = s_overflow | s_framing | s_parity | s_rx_gen;

	// Latch words are set at level so a condition still present after a
	// fault reset is latched again immediately.
	assign warn_lw.set_mask = (s_encoder  ? bit_mask(WARN_BIT_ENCODER) : WORD_ZERO)
	                        | (s_abs_pos  ? bit_mask(WARN_BIT_ABS_POS) : WORD_ZERO)
	                        | (modbus_any ? bit_mask(WARN_BIT_MODBUS)  : WORD_ZERO);
	assign warn_lw.clr      = fault_reset;

	wire sw_stop_event = sw_stop_req;
	assign fault_lw.set_mask = ((s_lim_pos | s_lim_neg) ? bit_mask(FAULT_BIT_LIMIT)  : WORD_ZERO)
	                         | (sw_stop_event ? bit_mask(FAULT_BIT_SW_STOP) : WORD_ZERO);
	assign fault_lw.clr      = fault_reset;

	// Refusal decode, highest priority first.
	wire is_mode     = cmd_kind == CMD_MODE;
	wire is_enable   = cmd_kind == CMD_ENABLE;
	wire in_fault    = (state_reg == ST_FAULT) || (state_reg == ST_FAULT_REACTION);
	wire in_qstop    = state_reg == ST_QSTOP;
	wire halt_decel  = halt_seen_reg && !s_still;
	wire rej_fault   = in_fault;
	wire rej_sw      = is_mode && sw_stop_reg;
	wire rej_int     = is_mode && int_stop_reg;
	wire rej_qstop   = is_mode && in_qstop;
	wire rej_halt    = halt_decel;
	wire rej_notrdy  = is_enable && (state_reg == ST_NOT_READY);
	wire rej_any     = rej_fault | rej_sw | rej_int | rej_qstop | rej_halt | rej_notrdy;
	// A refused command must not move the state, so transitions only see accepted ones.
	wire cmd_ok      = cmd_valid && !rej_any;

	// Events that move the operating state.
	wire limit_event  = pins_rise[6] | pins_rise[7];
	wire class1_event = class1_err | limit_event | sw_stop_event;
	wire powered      = (state_reg == ST_ENABLED) || (state_reg == ST_QSTOP);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_NOT_READY:
				if (s_init_done)
					state_next = ST_READY;
			ST_READY:
				if (cmd_ok && is_enable)
					state_next = ST_ENABLED;
			ST_ENABLED:
				if (cmd_ok && cmd_kind == CMD_DISABLE)
					state_next = ST_READY;
			ST_QSTOP:
				if (fault_reset)
					state_next = ST_ENABLED;
			ST_FAULT_REACTION:
				if (s_still)
					state_next = ST_FAULT;
			ST_FAULT:
				if (fault_reset)
					state_next = ST_READY;
		endcase
		// A class-1 event only forces quick stop from ST_ENABLED.
		if (class1_event && state_reg == ST_ENABLED)
			state_next = ST_QSTOP;
		if (class2_err && state_reg != ST_FAULT)
			state_next = ST_FAULT_REACTION;
	end

	wire [CODE_W-1:0] rej_code =
		rej_fault  ? CODE_FAULT_STATE :
		rej_sw     ? CODE_SW_STOP     :
		rej_int    ? CODE_INT_STOP    :
		rej_qstop  ? CODE_QSTOP       :
		rej_halt   ? CODE_HALT_DECEL  :
		rej_notrdy ? CODE_NOT_READY   : CODE_NONE;

	// An internal stop only matters while homing or jog is moving; elsewhere
	// the motion logic handles it and no refusal is wanted.
	function automatic logic int_stop_event_w();
		int_stop_event_w = int_sw_stop && homing_jog_active;
	endfunction

	// Newest detected condition, highest priority first.
	// The four link faults share warning bit 9, so only the code tells them apart.
	wire [CODE_W-1:0] det_code =
		sw_stop_event        ? CODE_SW_STOP     :
		pins_rise[6]         ? CODE_LIMIT_POS   :
		pins_rise[7]         ? CODE_LIMIT_NEG   :
		class1_err           ? CODE_QSTOP       :
		int_stop_event_w()   ? CODE_INT_STOP    :
		pins_rise[0]         ? CODE_ENCODER     :
		pins_rise[1]         ? CODE_ABS_POS     :
		pins_rise[2]         ? CODE_RX_OVERFLOW :
		pins_rise[3]         ? CODE_RX_FRAMING  :
		pins_rise[4]         ? CODE_RX_PARITY   :
		pins_rise[5]         ? CODE_RX_GENERAL  : CODE_NONE;

	wire [CLASS_W-1:0] det_class =
		(sw_stop_event || pins_rise[6] || pins_rise[7]) ? CLASS_1 : CLASS_0;
	wire det_any = det_code != CODE_NONE;
	wire cmd_rej = cmd_valid && rej_any;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= ST_NOT_READY;
			pins_prev_reg <= '0;
			halt_seen_reg <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			pins_prev_reg <= pins_sync;
			// Deceleration window opens at halt and closes at standstill.
			if (s_halt)
				halt_seen_reg <= 1'b1;
			else if (s_still)
				halt_seen_reg <= 1'b0;
		end
	end

	// Stop flags: the set wins over a fault reset in the same cycle.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_stop_reg  <= 1'b0;
			int_stop_reg <= 1'b0;
		end
		else
		begin
			sw_stop_reg  <= sw_stop_event | (sw_stop_reg & ~fault_reset);
			int_stop_reg <= int_stop_event_w() | (int_stop_reg & ~fault_reset);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resp_valid_reg   <= 1'b0;
			resp_refused_reg <= 1'b0;
			resp_code_reg    <= CODE_NONE;
		end
		else
		begin
			// Every command is answered, accepted or not, so the host can pair them.
			resp_valid_reg   <= cmd_valid;
			resp_refused_reg <= cmd_rej;
			resp_code_reg    <= cmd_rej ? rej_code : CODE_NONE;
		end
	end

	// Refusals are class 0 and become the most recent code unless a condition is detected in the same cycle.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_code_reg  <= CODE_NONE;
			last_class_reg <= CLASS_0;
		end
		else if (det_any)
		begin
			last_code_reg  <= det_code;
			last_class_reg <= det_class;
		end
		else if (cmd_rej)
		begin
			last_code_reg  <= rej_code;
			last_class_reg <= CLASS_0;
		end
	end

	assign resp_valid         = resp_valid_reg;
	assign resp_refused       = resp_refused_reg;
	assign resp_code          = resp_code_reg;
	assign warning_latch_word = warn_lw.word;
	assign fault_latch_word   = fault_lw.word;
	assign last_code          = last_code_reg;
	assign last_class         = last_class_reg;
	assign power_stage_on     = powered;
	assign quick_stop_active  = in_qstop;
	assign fault_active       = in_fault;
	// Limit switches stop motion as long as they are active.
	assign motion_stop        = in_qstop | in_fault | s_lim_pos | s_lim_neg;
endmodule

// file: dv/drive_err_checker.sv
// Purpose: Concurrent checks on the ports of the drive error reporting block.
// Assumes: One clock; the bench pulses each event by itself.
// Notes:   Pin paths allow for the two-flop synchroniser and edge detect.
`timescale 1ns/1ps
module drive_err_checker
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Causes
	input wire logic        encoder_err,
	input wire logic        limit_pos,
	input wire logic        class1_err,
	input wire logic        class2_err,
	input wire logic        cmd_valid,
	input wire logic        sw_stop_req,
	input wire logic        fault_reset,
	// Effects
	input wire logic        resp_valid,
	input wire logic        resp_refused,
	input wire logic [15:0] resp_code,
	input wire logic [31:0] warning_latch_word,
	input wire logic [31:0] fault_latch_word,
	input wire logic [15:0] last_code,
	input wire logic [2:0]  last_class,
	input wire logic        power_stage_on,
	input wire logic        quick_stop_active,
	input wire logic        fault_active,
	input wire logic        motion_stop
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	resp_follow_a: assert property (cmd_valid |=> resp_valid)
		else $error("No response one cycle after a command.");
	warn_sticky_a: assert property (!fault_reset |=>
		(warning_latch_word & $past(warning_latch_word)) == $past(warning_latch_word))
		else $error("Warning latch bit dropped without fault reset.");
	fault_sticky_a: assert property (!fault_reset |=>
		(fault_latch_word & $past(fault_latch_word)) == $past(fault_latch_word))
		else $error("Fault latch bit dropped without fault reset.");
	sw_stop_a: assert property (sw_stop_req |=>
		fault_latch_word[3] && last_code == 16'ha306 && last_class == 3'h1)
		else $error("Software stop not recorded.");
	encoder_bit_a: assert property ($rose(encoder_err) |-> ##[1:5] warning_latch_word[8])
		else $error("Encoder error not latched.");
	limit_stop_a: assert property ($rose(limit_pos) |-> ##[1:5] (fault_latch_word[1] && motion_stop))
		else $error("Positive limit did not stop and latch.");
	fault_refuse_a: assert property (cmd_valid && fault_active |=>
		resp_refused && resp_code == 16'ha308)
		else $error("Command in fault state not refused.");
	class2_enter_a: assert property (class2_err && !fault_reset |=> fault_active)
		else $error("Class 2 error did not enter fault.");
	class1_qstop_a: assert property (class1_err && power_stage_on && !fault_active && !fault_reset && !class2_err
		|=> quick_stop_active)
		else $error("Class 1 error did not enter quick stop.");
endmodule

// file: dv/motor_model.sv
// Purpose: Behavioural motor giving the standstill level to the block.
// Assumes: Motor moves after each accepted command.
// Notes:   Rest needs eight cycles of a held stop, so a quick command sees motion.
`timescale 1ns/1ps
module motor_model
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Stop causes and command results
	input  wire logic halt_req,
	input  wire logic motion_stop,
	input  wire logic resp_valid,
	input  wire logic resp_refused,
	// Motor state
	output logic      standstill
);
	logic [2:0] stop_cnt;
	wire        stopping = halt_req | motion_stop;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stop_cnt   <= 3'h0;
			standstill <= 1'b1;
		end
		else if (resp_valid && !resp_refused)
		begin
			stop_cnt   <= 3'h0;
			standstill <= 1'b0;
		end
		else if (stopping)
		begin
			stop_cnt   <= stop_cnt + 3'h1;
			standstill <= standstill | (stop_cnt == 3'h7);
		end
		else
			stop_cnt <= 3'h0;
	end
endmodule

// file: dv/drive_error_reporting_tb.sv
// Purpose: Directed command and event sequences for the error reporting block.
// Assumes: Inputs change on the falling edge; responses are read there too.
// Notes:   Pin levels are held five cycles to cross the synchroniser.
`timescale 1ns/1ps
module drive_error_reporting_tb;
	import drive_err_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  pins = 8'h00;
	logic [4:0]  ev = 5'h00;
	logic        halt_req = 1'b0;
	logic        init_done = 1'b0;
	logic        homing_jog_active = 1'b0;
	logic        cmd_valid = 1'b0;
	cmd_t        cmd_kind = CMD_OTHER;
	logic        standstill;
	logic        resp_valid, resp_refused, power_stage_on, quick_stop_active, fault_active;
	logic        motion_stop;
	logic [15:0] resp_code, last_code;
	logic [31:0] warning_latch_word, fault_latch_word;
	logic [2:0]  last_class;
	int          bad_count = 0;
	int          total_checks = 0;
	logic [4:0]  pin_bit [6] = '{5'h08, 5'h0d, 5'h09, 5'h09, 5'h09, 5'h09};
	logic [15:0] pin_code [8] = '{16'h7329, 16'h7338, 16'h7500, 16'h7501, 16'h7502, 16'h7503,
		16'ha302, 16'ha303};

	always #5 clk = ~clk;

	drive_error_reporting i_drive_error_reporting (.clk(clk), .rst_n(rst_n),
		.encoder_err(pins[0]), .abs_pos_unknown(pins[1]), .rx_overflow(pins[2]),
		.rx_framing(pins[3]), .rx_parity(pins[4]), .rx_general(pins[5]), .limit_pos(pins[6]),
		.limit_neg(pins[7]), .halt_req(halt_req), .standstill(standstill),
		.init_done(init_done), .class1_err(ev[2]), .class2_err(ev[3]), .int_sw_stop(ev[4]),
		.homing_jog_active(homing_jog_active), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.sw_stop_req(ev[0]), .fault_reset(ev[1]), .resp_valid(resp_valid),
		.resp_refused(resp_refused), .resp_code(resp_code),
		.warning_latch_word(warning_latch_word), .fault_latch_word(fault_latch_word),
		.last_code(last_code), .last_class(last_class), .power_stage_on(power_stage_on),
		.quick_stop_active(quick_stop_active), .fault_active(fault_active),
		.motion_stop(motion_stop));
	motor_model i_motor_model (.clk(clk), .rst_n(rst_n), .halt_req(halt_req),
		.motion_stop(motion_stop), .resp_valid(resp_valid), .resp_refused(resp_refused),
		.standstill(standstill));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One command; the answer is read in the cycle after the taking edge.
	task automatic cmd(input cmd_t k, input logic refused, input logic [15:0] code);
		cmd_valid = 1'b1;
		cmd_kind = k;
		@(negedge clk);
		cmd_valid = 1'b0;
		chk(resp_valid, 1'b1);
		chk(resp_refused, refused);
		chk(resp_code, code);
	endtask

	task automatic pulse(input int i);
		ev[i] = 1'b1;
		@(negedge clk);
		ev[i] = 1'b0;
	endtask

	task automatic wait_rest;
		for (int n = 0; n < 40 && standstill !== 1'b1; n++)
			@(negedge clk);
		chk(standstill, 1'b1);
		repeat (3) @(negedge clk);
	endtask

	initial
	begin
		#100us;
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		chk(warning_latch_word | fault_latch_word, 32'h0);
		cmd(CMD_ENABLE, 1'b1, 16'ha305);
		chk({last_code, 13'h0, last_class}, {16'ha305, 16'h0});
		init_done = 1'b1;
		repeat (4) @(negedge clk);
		cmd(CMD_ENABLE, 1'b0, 16'h0000);
		chk(power_stage_on, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			// Clear first so that each pin must set its own bit.
			repeat (3) @(negedge clk);
			pulse(1);
			chk(warning_latch_word, 32'h0);
			pins[i] = 1'b1;
			repeat (5) @(negedge clk);
			pins[i] = 1'b0;
			chk(warning_latch_word[pin_bit[i]], 1'b1);
			chk({last_code, 13'h0, last_class}, {pin_code[i], 16'h0});
		end
		repeat (3) @(negedge clk);
		chk(warning_latch_word, 32'h0000_0200);
		pulse(1);
		chk(warning_latch_word, 32'h0);
		halt_req = 1'b1;
		repeat (4) @(negedge clk);
		cmd(CMD_MODE, 1'b1, 16'ha300);
		wait_rest();
		halt_req = 1'b0;
		repeat (4) @(negedge clk);
		cmd(CMD_MODE, 1'b0, 16'h0000);
		pulse(0);
		chk(quick_stop_active, 1'b1);
		chk(fault_latch_word, 32'h8);
		cmd(CMD_MODE, 1'b1, 16'ha306);
		pulse(1);
		cmd(CMD_MODE, 1'b0, 16'h0000);
		pulse(2);
		chk(quick_stop_active, 1'b1);
		cmd(CMD_MODE, 1'b1, 16'ha301);
		pulse(1);
		homing_jog_active = 1'b1;
		pulse(4);
		cmd(CMD_MODE, 1'b1, 16'ha307);
		pulse(1);
		homing_jog_active = 1'b0;
		cmd(CMD_MODE, 1'b0, 16'h0000);
		for (int i = 6; i < 8; i++)
		begin
			pins[i] = 1'b1;
			repeat (5) @(negedge clk);
			chk(motion_stop, 1'b1);
			chk(fault_latch_word, 32'h2);
			chk({last_code, 13'h0, last_class}, {pin_code[i], 16'h1});
			pins[i] = 1'b0;
			repeat (4) @(negedge clk);
			pulse(1);
			chk(fault_latch_word, 32'h0);
		end
		pulse(3);
		chk(fault_active, 1'b1);
		cmd(CMD_MODE, 1'b1, 16'ha308);
		wait_rest();
		pulse(1);
		chk(fault_active, 1'b0);
		report_and_stop();
	end
endmodule

bind drive_error_reporting drive_err_checker i_drive_err_checker (.clk(clk), .rst_n(rst_n),
	.encoder_err(encoder_err), .limit_pos(limit_pos), .class1_err(class1_err),
	.class2_err(class2_err), .cmd_valid(cmd_valid), .sw_stop_req(sw_stop_req),
	.fault_reset(fault_reset), .resp_valid(resp_valid), .resp_refused(resp_refused),
	.resp_code(resp_code), .warning_latch_word(warning_latch_word),
	.fault_latch_word(fault_latch_word), .last_code(last_code), .last_class(last_class),
	.power_stage_on(power_stage_on), .quick_stop_active(quick_stop_active),
	.fault_active(fault_active), .motion_stop(motion_stop));
